/* File: rtl/bitmap_consts.svh */
// constants of the coil and discrete-input reference map
`ifndef BITMAP_CONSTS_SVH
`define BITMAP_CONSTS_SVH
`define FC_READ_COILS 8'h01
`define FC_READ_INPUTS 8'h02
`define FC_FORCE_SINGLE 8'h05
`define FC_FORCE_MULTI 8'h0f
`define EXC_ILLEGAL_FUNC 8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`define COIL_FORCE_ON 16'hff00
`define COIL_FORCE_OFF 16'h0000
`define CTRL_WORD_BITS 32
`define RELAY_COUNT 6
`define DIN_COUNT 6
`define RELAY_BASE 16'h0020
`define DIN_BASE 16'h0020
`define MASK_LIMITED 32'h0000_08ef
`define MASK_EXTENDED 32'h000f_fff7
`define MASK_FULL 32'h0000_0cff
`define PROF_LIMITED 2'h0
`define PROF_EXTENDED 2'h1
`define PROF_FULL 2'h2
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_REQ 32'h0000_0008
`define REG_RESULT 32'h0000_000c
`define REG_RDATA 32'h0000_0010
`define REG_WVALS 32'h0000_0014
`define REG_CTLWORD 32'h0000_0018
`define REG_RELAY 32'h0000_001c
`define REQ_GO_BIT 31
`define CTRL_FB_EN_BIT 2
`define STAT_BUSY_BIT 0
`endif

/* File: rtl/bitmap_pkg.sv */
// types for the coil and discrete-input reference map
package bitmap_pkg;
  typedef logic [1:0] profile_t;
  typedef logic [7:0] func_code_t;
  typedef logic [15:0] ref_addr_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_WALK = 4'b0100,
    ST_DONE = 4'b1000
  } txn_state_e;
endpackage : bitmap_pkg

/* File: rtl/status_word_map.sv */
// status-word assembly for the discrete-input image
`timescale 1ns/1ps
`include "bitmap_consts.svh"
module status_word_map
  import bitmap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // profile and drive state
  input wire bitmap_pkg::profile_t profile,
  input wire logic [4:0] legacy_status,
  input wire logic [4:0] extended_status,
  // assembled word
  output logic [31:0] status_word
);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_word <= 32'h0000_0000;
    end else if (profile == `PROF_EXTENDED) begin
      status_word <= {27'h0000000, extended_status};
    end else begin
      status_word <= {27'h0000000, legacy_status};
    end
  end
endmodule : status_word_map

/* File: rtl/coil_image.sv */
// control-word coil image with per-profile write mask
`timescale 1ns/1ps
`include "bitmap_consts.svh"
module coil_image
  import bitmap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // profile and single-bit force
  input wire bitmap_pkg::profile_t profile,
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire logic wr_val,
  // image
  output logic [31:0] ctrl_word,
  output logic [`RELAY_COUNT-1:0] relay_out
);
  logic [31:0] mask;
  logic [31:0] raw_q;

  always_comb begin
    unique case (profile)
      `PROF_EXTENDED: mask = `MASK_EXTENDED;
      `PROF_FULL: mask = `MASK_FULL;
      default: mask = `MASK_LIMITED;
    endcase
  end

  // masked bits are dropped on write and reread as zero; raw_q is not cleared on a profile
  // change, so bits written under another profile that the new mask allows stay visible
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_q <= 32'h0000_0000;
    end else if (wr_en && !wr_idx[5]) begin
      raw_q[wr_idx[4:0]] <= wr_val & mask[wr_idx[4:0]];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      relay_out <= '0;
    end else if (wr_en && wr_idx[5] && wr_idx[4:0] < `RELAY_COUNT) begin
      relay_out[wr_idx[2:0]] <= wr_val;
    end
  end

  assign ctrl_word = raw_q & mask;
endmodule : coil_image

/* File: rtl/fieldbus_bit_reference_map.sv */
// coil and discrete-input reference map with apb request port
`timescale 1ns/1ps
`include "bitmap_consts.svh"
module fieldbus_bit_reference_map
  import bitmap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive state
  input wire logic [4:0] legacy_status,
  input wire logic [4:0] extended_status,
  input wire logic [`DIN_COUNT-1:0] hw_inputs,
  // drive commands
  output logic [31:0] control_word,
  output logic [`RELAY_COUNT-1:0] relay_states,
  output logic [1:0] word_profile_select
);
  import bitmap_pkg::*;

  txn_state_e state_q;
  logic fb_enable_q;
  profile_t profile_q;
  func_code_t func_q;
  ref_addr_t start_q;
  logic [5:0] count_q;
  logic [5:0] step_q;
  logic [31:0] wvals_q;
  logic [31:0] rdata_q;
  logic [7:0] exc_q;
  logic done_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [`DIN_COUNT-1:0] din_meta_q;
  logic [`DIN_COUNT-1:0] din_sync_q;
  logic [31:0] ctrl_word;
  logic [`RELAY_COUNT-1:0] relay_w;
  logic [31:0] status_word;
  logic img_wr;
  logic [5:0] img_idx;
  logic img_val;
  logic [16:0] end_addr;
  logic addr_ok;
  logic func_ok;
  ref_addr_t cur_addr;
  logic cur_bit;
  logic bus_wr;
  logic bus_rd;
  logic bus_acc;
  logic hit_rd;
  logic hit_wr;
  logic [31:0] rd_word;
  logic req_go;
  logic walk_last;

  // the answer is prepared on the first access edge; a write commits only
  // on the edge where the master sees pready, never before
  assign bus_acc = psel && penable && !pready_q;
  assign bus_rd = bus_acc && !pwrite;
  assign bus_wr = psel && penable && pwrite && pready_q;
  assign req_go = bus_wr && paddr == `REG_REQ && pwdata[`REQ_GO_BIT] &&
    state_q == ST_IDLE;
  assign walk_last = func_q == `FC_FORCE_SINGLE || step_q + 6'h01 == count_q;

  coil_image u_coils (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .profile(profile_q),
    .wr_en(img_wr),
    .wr_idx(img_idx),
    .wr_val(img_val),
    .ctrl_word(ctrl_word),
    .relay_out(relay_w)
  );

  status_word_map u_status (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .profile(profile_q),
    .legacy_status(legacy_status),
    .extended_status(extended_status),
    .status_word(status_word)
  );

  // hardware inputs arrive from pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      din_meta_q <= '0;
      din_sync_q <= '0;
    end else begin
      din_meta_q <= hw_inputs;
      din_sync_q <= din_meta_q;
    end
  end

  // request checks
  assign end_addr = {1'b0, start_q} + {11'h000, count_q};
  always_comb begin
    func_ok = 1'b1;
    addr_ok = 1'b0;
    unique case (func_q)
      `FC_READ_COILS, `FC_FORCE_MULTI: begin
        addr_ok = count_q != 6'h00 &&
          count_q <= 6'(`CTRL_WORD_BITS) &&
          end_addr <= {1'b0, `RELAY_BASE} + 17'(`RELAY_COUNT);
      end
      `FC_FORCE_SINGLE: begin
        addr_ok = start_q < `RELAY_BASE + 16'(`RELAY_COUNT);
      end
      `FC_READ_INPUTS: begin
        addr_ok = count_q != 6'h00 &&
          count_q <= 6'(`CTRL_WORD_BITS) &&
          end_addr <= {1'b0, `DIN_BASE} + 17'(`DIN_COUNT);
      end
      default: func_ok = 1'b0;
    endcase
  end

  assign cur_addr = start_q + {10'h000, step_q};
  always_comb begin
    cur_bit = 1'b0;
    if (func_q == `FC_READ_INPUTS) begin
      if (cur_addr < `DIN_BASE) begin
        cur_bit = status_word[cur_addr[4:0]];
      end else begin
        cur_bit = din_sync_q[cur_addr[2:0]];
      end
    end else if (cur_addr < `RELAY_BASE) begin
      cur_bit = ctrl_word[cur_addr[4:0]];
    end else begin
      cur_bit = relay_w[cur_addr[2:0]];
    end
  end

  // a force is only applied while fieldbus control is granted
  always_comb begin
    img_wr = 1'b0;
    img_idx = cur_addr[5:0];
    img_val = wvals_q[step_q[4:0]];
    if (state_q == ST_WALK && fb_enable_q) begin
      if (func_q == `FC_FORCE_MULTI) begin
        img_wr = 1'b1;
      end else if (func_q == `FC_FORCE_SINGLE) begin
        img_wr = 1'b1;
        img_val = wvals_q[0];
      end
    end
  end

  // one request in flight, like a half-duplex single-client link
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (req_go) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (!func_ok || !addr_ok) begin
            state_q <= ST_DONE;
          end else begin
            state_q <= ST_WALK;
          end
        end
        ST_WALK: begin
          if (walk_last) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      step_q <= 6'h00;
    end else if (state_q == ST_CHECK) begin
      step_q <= 6'h00;
    end else if (state_q == ST_WALK) begin
      step_q <= step_q + 6'h01;
    end
  end

  // bits are captured before a force lands, so a refused force still
  // returns the current states
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (state_q == ST_CHECK) begin
      rdata_q <= 32'h0000_0000;
    end else if (state_q == ST_WALK) begin
      rdata_q[step_q[4:0]] <= cur_bit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      exc_q <= 8'h00;
    end else if (state_q == ST_CHECK) begin
      if (!func_ok) begin
        exc_q <= `EXC_ILLEGAL_FUNC;
      end else if (!addr_ok) begin
        exc_q <= `EXC_ILLEGAL_ADDR;
      end else begin
        exc_q <= 8'h00;
      end
    end
  end

  // done stands until the next request is taken
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else if (req_go) begin
      done_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      done_q <= 1'b1;
    end
  end

  // profile and fieldbus grant
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_enable_q <= 1'b0;
      profile_q <= `PROF_LIMITED;
    end else if (bus_wr && paddr == `REG_CTRL) begin
      profile_q <= pwdata[1:0];
      fb_enable_q <= pwdata[`CTRL_FB_EN_BIT];
    end
  end

  // request fields and force values are frozen while a request runs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      func_q <= 8'h00;
      start_q <= 16'h0000;
      count_q <= 6'h00;
    end else if (bus_wr && paddr == `REG_REQ && state_q == ST_IDLE) begin
      func_q <= pwdata[7:0];
      start_q <= pwdata[23:8];
      count_q <= pwdata[29:24];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wvals_q <= 32'h0000_0000;
    end else if (bus_wr && paddr == `REG_WVALS && state_q == ST_IDLE) begin
      wvals_q <= pwdata;
    end
  end

  // read mux and writable map; a miss on either answers with pslverr
  always_comb begin
    hit_rd = 1'b1;
    hit_wr = 1'b0;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `REG_CTRL: begin
        rd_word = {29'h0, fb_enable_q, profile_q};
        hit_wr = 1'b1;
      end
      `REG_STATUS: rd_word = {30'h0, done_q, state_q != ST_IDLE};
      `REG_REQ: begin
        rd_word = {2'h0, count_q, start_q, func_q};
        hit_wr = 1'b1;
      end
      `REG_RESULT: rd_word = {24'h0, exc_q};
      `REG_RDATA: rd_word = rdata_q;
      `REG_WVALS: begin
        rd_word = wvals_q;
        hit_wr = 1'b1;
      end
      `REG_CTLWORD: rd_word = ctrl_word;
      `REG_RELAY: rd_word = {26'h0, relay_w};
      default: hit_rd = 1'b0;
    endcase
  end

  // apb answer: one wait state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pslverr_q <= 1'b0;
    end else if (bus_rd) begin
      pslverr_q <= !hit_rd;
    end else if (bus_acc) begin
      pslverr_q <= !hit_wr;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // read data only stands beside pready, zero otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (bus_rd) begin
      prdata_q <= rd_word;
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // registered copies to the drive
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_word <= 32'h0000_0000;
      relay_states <= '0;
      word_profile_select <= `PROF_LIMITED;
    end else begin
      control_word <= ctrl_word;
      relay_states <= relay_w;
      word_profile_select <= profile_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule : fieldbus_bit_reference_map

/* File: verif/fieldbus_bit_reference_map_asserts.sv */
// concurrent checks on the apb answer and the masked control word
`timescale 1ns/1ps
`include "bitmap_consts.svh"
module fbrm_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // drive commands
  input wire logic [31:0] control_word,
  input wire logic [1:0] word_profile_select
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // last profile written, so the copy can be checked a few cycles later
  logic [1:0] want_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) want_q <= 2'h0;
    else if (pready && pwrite && paddr == `REG_CTRL) want_q <= pwdata[1:0];
  end
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_answer_time: assert property
    (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one cycle after access");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_err_on_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_mask_limited: assert property
    ((word_profile_select == `PROF_LIMITED) [*3] |->
     (control_word & ~`MASK_LIMITED) == 32'h0)
    else $error("void bit set in limited profile");
  a_mask_ext: assert property
    ((word_profile_select == `PROF_EXTENDED) [*3] |->
     (control_word & ~`MASK_EXTENDED) == 32'h0)
    else $error("void bit set in extended profile");
  a_mask_full: assert property
    ((word_profile_select == `PROF_FULL) [*3] |->
     (control_word & ~`MASK_FULL) == 32'h0)
    else $error("void bit set in full profile");
  a_reserved_zero: assert property (control_word[31:20] == 12'h0)
    else $error("reserved coil set");
  a_profile_set: assert property
    (pready && pwrite && !pslverr && paddr == `REG_CTRL &&
     pwdata[1:0] != 2'h3 |=> ##[0:2] word_profile_select == want_q)
    else $error("profile copy not updated");
endmodule : fbrm_checker

bind fieldbus_bit_reference_map fbrm_checker chk (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .control_word(control_word),
  .word_profile_select(word_profile_select)
);

/* File: verif/fb_client_model.sv */
// serial client model issuing coil and input requests over apb
`timescale 1ns/1ps
`include "bitmap_consts.svh"
module fb_client_model (
  // clock
  input wire logic core_clk,
  // apb master
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [31:0] paddr = 32'h0,
  output logic [31:0] pwdata = 32'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // requests whose done flag never came within the poll limit
  int stalls = 0;
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show junk, never the last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  // one request at a time, polled to completion
  task automatic req(input logic [7:0] fc, input int ref_num,
                     input logic [5:0] qty, input logic [31:0] wv,
                     output logic [7:0] exc, output logic [31:0] bits);
    logic [31:0] r;
    logic e;
    int n;
    xfer(1'b1, `REG_WVALS, wv, r, e);
    xfer(1'b1, `REG_REQ, {2'b10, qty, 16'(ref_num - 1), fc}, r, e);
    n = 0;
    do begin
      xfer(1'b0, `REG_STATUS, 32'h0, r, e);
      n++;
    end while (r[1] !== 1'b1 && n < 50);
    if (r[1] !== 1'b1) stalls++;
    xfer(1'b0, `REG_RESULT, 32'h0, r, e);
    exc = r[7:0];
    xfer(1'b0, `REG_RDATA, 32'h0, bits, e);
  endtask : req
endmodule : fb_client_model

/* File: verif/fieldbus_bit_reference_map_bench.sv */
// self-checking bench for the coil and discrete-input map
`timescale 1ns/1ps
`include "bitmap_consts.svh"
module fieldbus_bit_reference_map_bench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] legacy_status = 5'h0;
  logic [4:0] extended_status = 5'h0;
  logic [5:0] hw_inputs = 6'h0;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [31:0] paddr, pwdata, prdata, control_word;
  wire logic [5:0] relay_states;
  wire logic [1:0] word_profile_select;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'd85486;
  logic [31:0] r, v, bits;
  logic [7:0] exc;
  logic e;
  always #12.5 core_clk = ~core_clk;
  fb_client_model client (.core_clk(core_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fieldbus_bit_reference_map dut (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .legacy_status(legacy_status), .extended_status(extended_status),
    .hw_inputs(hw_inputs), .control_word(control_word),
    .relay_states(relay_states), .word_profile_select(word_profile_select));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] mask_of(input int p);
    return p == 1 ? `MASK_EXTENDED : p == 2 ? `MASK_FULL : `MASK_LIMITED;
  endfunction : mask_of
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, g, x);
    end
  endtask : chk_word
  task automatic chk_flag(input logic g, input logic x);
    chk_word({31'h0, g}, {31'h0, x});
  endtask : chk_flag
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #500us;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    client.xfer(1'b0, 32'h0000_0040, 32'h0, r, e);
    chk_flag(e, 1'b1);
    client.xfer(1'b1, `REG_STATUS, 32'h0, r, e);
    chk_flag(e, 1'b1);
    client.req(8'h03, 1, 6'd1, 32'h0, exc, bits);
    chk_word({24'h0, exc}, {24'h0, `EXC_ILLEGAL_FUNC});
    client.req(`FC_READ_COILS, 39, 6'd1, 32'h0, exc, bits);
    chk_word({24'h0, exc}, {24'h0, `EXC_ILLEGAL_ADDR});
    client.req(`FC_READ_COILS, 1, 6'd33, 32'h0, exc, bits);
    chk_word({24'h0, exc}, {24'h0, `EXC_ILLEGAL_ADDR});
    $display("test refusals done");
    for (int p = 0; p < 3; p++) begin
      client.xfer(1'b1, `REG_CTRL, 32'h4 | p, r, e);
      v = rnd();
      client.req(`FC_FORCE_MULTI, 1, 6'd32, v, exc, bits);
      client.xfer(1'b0, `REG_CTLWORD, 32'h0, r, e);
      chk_word(r, v & mask_of(p));
      chk_flag(e, 1'b0);
      chk_word(control_word, v & mask_of(p));
      client.req(`FC_READ_COILS, 1, 6'd32, 32'h0, exc, bits);
      chk_word(bits, v & mask_of(p));
      v = rnd();
      legacy_status <= v[4:0];
      extended_status <= v[9:5];
      client.req(`FC_READ_INPUTS, 1, 6'd5, 32'h0, exc, bits);
      chk_word({27'h0, bits[4:0]}, {27'h0, p == 1 ? v[9:5] : v[4:0]});
    end
    $display("test profiles done");
    for (int k = 0; k < 6; k++)
      client.req(`FC_FORCE_SINGLE, 33 + k, 6'd1, 32'h1, exc, bits);
    chk_word({26'h0, relay_states}, 32'h3f);
    client.xfer(1'b0, `REG_RELAY, 32'h0, r, e);
    chk_word(r, 32'h0000_003f);
    client.xfer(1'b1, `REG_CTRL, 32'h2, r, e);
    client.req(`FC_FORCE_SINGLE, 33, 6'd1, 32'h0, exc, bits);
    chk_word({26'h0, relay_states}, 32'h3f);
    chk_flag(bits[0], 1'b1);
    $display("test relays done");
    v = rnd();
    hw_inputs <= v[5:0];
    client.req(`FC_READ_INPUTS, 33, 6'd6, 32'h0, exc, bits);
    chk_word({26'h0, bits[5:0]}, {26'h0, v[5:0]});
    $display("test inputs done");
    chk_word(32'(client.stalls), 32'h0);
    give_verdict();
  end
endmodule : fieldbus_bit_reference_map_bench
